// File: core/vic_pkg.sv
// constants shared by the vectored interrupt controller
package vic_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] OFS_EDGE = 8'h00;
  localparam logic [7:0] OFS_CTRL0 = 8'h04;
  localparam logic [7:0] OFS_CTRL1 = 8'h08;
  localparam logic [7:0] OFS_UART_TB = 8'h0C;
  localparam logic [7:0] OFS_CTMR = 8'h10;
  localparam logic [7:0] OFS_STMR = 8'h14;
  localparam logic [7:0] OFS_EE_LV = 8'h18;
  localparam logic [7:0] OFS_PULLUP = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  // primary control register 0
  localparam int C0_ADC_FLAG = 6;
  localparam int C0_PIN1_FLAG = 5;
  localparam int C0_PIN0_FLAG = 4;
  localparam int C0_ADC_EN = 3;
  localparam int C0_PIN1_EN = 2;
  localparam int C0_PIN0_EN = 1;
  localparam int C0_GLOBAL_EN = 0;
  // primary control register 1
  localparam int C1_SPI_FLAG = 7;
  localparam int C1_MF2_FLAG = 6;
  localparam int C1_MF1_FLAG = 5;
  localparam int C1_MF0_FLAG = 4;
  localparam int C1_SPI_EN = 3;
  localparam int C1_MF2_EN = 2;
  localparam int C1_MF1_EN = 1;
  localparam int C1_MF0_EN = 0;
  // uart and time base register
  localparam int C2_UART_FLAG = 6;
  localparam int C2_TB1_FLAG = 5;
  localparam int C2_TB0_FLAG = 4;
  localparam int C2_UART_EN = 2;
  localparam int C2_TB1_EN = 1;
  localparam int C2_TB0_EN = 0;
  // multi-function group registers share one layout
  localparam int MF_A_FLAG = 5;
  localparam int MF_P_FLAG = 4;
  localparam int MF_A_EN = 1;
  localparam int MF_P_EN = 0;
  // implemented bits and flag bits per register
  localparam logic [7:0] MASK_EDGE = 8'h0F;
  localparam logic [7:0] MASK_CTRL0 = 8'h7F;
  localparam logic [7:0] MASK_CTRL1 = 8'hFF;
  localparam logic [7:0] MASK_CTRL1_SMALL = 8'hDD;
  localparam logic [7:0] MASK_UART_TB = 8'h77;
  localparam logic [7:0] MASK_MF = 8'h33;
  localparam logic [7:0] MASK_PULLUP = 8'h03;
  localparam logic [7:0] FLAGS_HI = 8'hF0;
  localparam logic [7:0] REG_RESET = 8'h00;
  // edge select codes
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // vector indices
  localparam int NUM_VEC = 10;
  localparam int VEC_W = 4;
  localparam int V_PIN0 = 0;
  localparam int V_PIN1 = 1;
  localparam int V_ADC = 2;
  localparam int V_MF0 = 3;
  localparam int V_MF1 = 4;
  localparam int V_MF2 = 5;
  localparam int V_SPI = 6;
  localparam int V_TB0 = 7;
  localparam int V_TB1 = 8;
  localparam int V_UART = 9;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;
endpackage : vic_pkg

// File: core/vic_stack_mem.sv
// return address stack storage with registered read data
`timescale 1ns/1ps
module vic_stack_mem #(
  parameter int W = 14,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (re) begin
      rdata <= mem[raddr];
    end
  end
endmodule : vic_stack_mem

// File: core/vic_ctrl.sv
// vectored interrupt controller with ahb-lite register slave
//
// The implementer's own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
module vic_ctrl
  import vic_pkg::*;
#(
  parameter int PC_W = 14,
  parameter int STACK_DEPTH = 8,
  parameter bit HAS_STD_TMR = 1'b1,
  // slot 0 is the highest priority; each slot holds a vector index
  parameter logic [vic_pkg::NUM_VEC*vic_pkg::VEC_W-1:0] PRIO_ORDER =
    {4'h9, 4'h8, 4'h7, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0},
  parameter logic [vic_pkg::NUM_VEC*14-1:0] VEC_ADDR =
    {14'h0028, 14'h0024, 14'h0020, 14'h001C, 14'h0018,
     14'h0014, 14'h0010, 14'h000C, 14'h0008, 14'h0004}
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [1:0] ext_pin,
  input wire logic adc_done,
  input wire logic spi_event,
  input wire logic uart_event,
  input wire logic timebase0_event,
  input wire logic timebase1_event,
  input wire logic compact_tmr_match_a,
  input wire logic compact_tmr_match_p,
  input wire logic standard_tmr_match_a,
  input wire logic standard_tmr_match_p,
  input wire logic eeprom_write_done,
  input wire logic low_volt_detect,
  input wire logic [PC_W-1:0] core_next_pc,
  input wire logic return_from_irq,
  output logic irq_call,
  output logic [PC_W-1:0] irq_vector,
  output logic resume_valid,
  output logic [PC_W-1:0] resume_pc,
  output logic wake_req,
  output logic [1:0] ext_pullup_en
);
  localparam int SP_W = $clog2(STACK_DEPTH + 1);
  localparam int SA_W = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;
  localparam logic [SP_W-1:0] SP_FULL = SP_W'(STACK_DEPTH);
  localparam logic [SP_W-1:0] SP_ONE = SP_W'(1);

  // set wins over both the software write and the service clear
  function automatic logic [7:0] upd(input logic [7:0] cur, input logic wr,
                                     input logic [7:0] wd, input logic [7:0] clr,
                                     input logic [7:0] set, input logic [7:0] mask);
    upd = (((wr ? wd : cur) & ~clr) | set) & mask;
  endfunction : upd

  function automatic logic edge_hit(input logic [1:0] sel, input logic cur,
                                    input logic prev);
    logic rise;
    logic fall;
    rise = cur & ~prev;
    fall = ~cur & prev;
    case (sel)
      EDGE_RISE: edge_hit = rise;
      EDGE_FALL: edge_hit = fall;
      EDGE_BOTH: edge_hit = rise | fall;
      default: edge_hit = 1'b0;
    endcase
  endfunction : edge_hit

  function automatic logic [VEC_W-1:0] pick(input logic [NUM_VEC-1:0] req);
    logic found;
    logic [VEC_W-1:0] idx;
    found = 1'b0;
    pick = '0;
    for (int k = NUM_VEC - 1; k >= 0; k--) begin
      idx = PRIO_ORDER[k*VEC_W +: VEC_W];
      if (req[idx]) begin
        found = 1'b1;
        pick = idx;
      end
    end
  endfunction : pick

  // registers
  logic [7:0] edge_reg;
  logic [7:0] ctrl0_reg;
  logic [7:0] ctrl1_reg;
  logic [7:0] uart_tb_reg;
  logic [7:0] ctmr_reg;
  logic [7:0] stmr_reg;
  logic [7:0] ee_lv_reg;
  logic [7:0] pullup_reg;
  logic [7:0] edge_next;
  logic [7:0] ctrl0_next;
  logic [7:0] ctrl1_next;
  logic [7:0] uart_tb_next;
  logic [7:0] ctmr_next;
  logic [7:0] stmr_next;
  logic [7:0] ee_lv_next;
  logic [7:0] pullup_next;
  logic [SP_W-1:0] sp_reg;
  logic wr_pend_reg;
  logic [7:0] wr_ofs_reg;
  logic [1:0] pin_s1_reg;
  logic [1:0] pin_s2_reg;
  logic [1:0] pin_prev_reg;
  logic pop_reg;

  // bus decode
  wire addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ);
  wire in_map = (haddr[31:8] == 24'h0);
  wire rd_go = addr_phase && !hwrite;
  wire wr_go = addr_phase && hwrite && in_map;
  wire [7:0] wd = hwdata[7:0];
  wire we_edge = wr_pend_reg && (wr_ofs_reg == OFS_EDGE);
  wire we_c0 = wr_pend_reg && (wr_ofs_reg == OFS_CTRL0);
  wire we_c1 = wr_pend_reg && (wr_ofs_reg == OFS_CTRL1);
  wire we_c2 = wr_pend_reg && (wr_ofs_reg == OFS_UART_TB);
  wire we_ct = wr_pend_reg && (wr_ofs_reg == OFS_CTMR);
  wire we_st = wr_pend_reg && (wr_ofs_reg == OFS_STMR);
  wire we_el = wr_pend_reg && (wr_ofs_reg == OFS_EE_LV);
  wire we_pu = wr_pend_reg && (wr_ofs_reg == OFS_PULLUP);

  // the smaller variant has no standard timer group
  wire [7:0] mask_c1 = HAS_STD_TMR ? MASK_CTRL1 : MASK_CTRL1_SMALL;
  wire [7:0] mask_st = HAS_STD_TMR ? MASK_MF : REG_RESET;

  // external pins: two flops, then edge detection on the settled copy
  wire [1:0] pin_hit;
  assign pin_hit[0] = edge_hit(edge_reg[1:0], pin_s2_reg[0], pin_prev_reg[0]);
  assign pin_hit[1] = edge_hit(edge_reg[3:2], pin_s2_reg[1], pin_prev_reg[1]);

  // member flags set on their events; groups follow any member event
  wire ct_a = compact_tmr_match_a;
  wire ct_p = compact_tmr_match_p;
  wire st_a = standard_tmr_match_a && HAS_STD_TMR;
  wire st_p = standard_tmr_match_p && HAS_STD_TMR;
  wire [2:0] mf_hit;
  assign mf_hit[0] = ct_a || ct_p;
  assign mf_hit[1] = st_a || st_p;
  assign mf_hit[2] = eeprom_write_done || low_volt_detect;

  // requests: flag and its own enable, then global, stack and return gating
  wire [NUM_VEC-1:0] req;
  assign req[V_PIN0] = ctrl0_reg[C0_PIN0_FLAG] && ctrl0_reg[C0_PIN0_EN];
  assign req[V_PIN1] = ctrl0_reg[C0_PIN1_FLAG] && ctrl0_reg[C0_PIN1_EN];
  assign req[V_ADC] = ctrl0_reg[C0_ADC_FLAG] && ctrl0_reg[C0_ADC_EN];
  assign req[V_MF0] = ctrl1_reg[C1_MF0_FLAG] && ctrl1_reg[C1_MF0_EN];
  assign req[V_MF1] = ctrl1_reg[C1_MF1_FLAG] && ctrl1_reg[C1_MF1_EN];
  assign req[V_MF2] = ctrl1_reg[C1_MF2_FLAG] && ctrl1_reg[C1_MF2_EN];
  assign req[V_SPI] = ctrl1_reg[C1_SPI_FLAG] && ctrl1_reg[C1_SPI_EN];
  assign req[V_TB0] = uart_tb_reg[C2_TB0_FLAG] && uart_tb_reg[C2_TB0_EN];
  assign req[V_TB1] = uart_tb_reg[C2_TB1_FLAG] && uart_tb_reg[C2_TB1_EN];
  assign req[V_UART] = uart_tb_reg[C2_UART_FLAG] && uart_tb_reg[C2_UART_EN];

  wire stack_full = (sp_reg == SP_FULL);
  wire stack_empty = (sp_reg == '0);
  // a return in the same cycle wins; the next service waits one cycle
  wire svc_go = ctrl0_reg[C0_GLOBAL_EN] && (|req) && !stack_full
                && !return_from_irq;
  wire [VEC_W-1:0] svc_idx = pick(req);
  wire [NUM_VEC-1:0] svc_hot = svc_go ? (NUM_VEC'(1) << svc_idx) : '0;
  wire pop_go = return_from_irq && !stack_empty;

  // service clears: global enable plus the serviced vector's own flag only
  wire [7:0] c0_clr = {1'b0, svc_hot[V_ADC], svc_hot[V_PIN1], svc_hot[V_PIN0],
                       3'h0, svc_go};
  wire [7:0] c1_clr = {svc_hot[V_SPI], svc_hot[V_MF2], svc_hot[V_MF1],
                       svc_hot[V_MF0], 4'h0};
  wire [7:0] c2_clr = {1'b0, svc_hot[V_UART], svc_hot[V_TB1], svc_hot[V_TB0], 4'h0};

  // event sets; the return restores the global enable
  wire [7:0] c0_set = {1'b0, adc_done, pin_hit[1], pin_hit[0], 3'h0, pop_go};
  wire [7:0] c1_set = {spi_event, mf_hit[2], mf_hit[1], mf_hit[0], 4'h0};
  wire [7:0] c2_set = {1'b0, uart_event, timebase1_event, timebase0_event, 4'h0};
  wire [7:0] ct_set = {2'h0, ct_a, ct_p, 4'h0};
  wire [7:0] st_set = {2'h0, st_a, st_p, 4'h0};
  wire [7:0] el_set = {2'h0, eeprom_write_done, low_volt_detect, 4'h0};

  // member flags are never cleared by service
  assign edge_next = upd(edge_reg, we_edge, wd, REG_RESET, REG_RESET, MASK_EDGE);
  assign ctrl0_next = upd(ctrl0_reg, we_c0, wd, c0_clr, c0_set, MASK_CTRL0);
  assign ctrl1_next = upd(ctrl1_reg, we_c1, wd, c1_clr, c1_set, mask_c1);
  assign uart_tb_next = upd(uart_tb_reg, we_c2, wd, c2_clr, c2_set, MASK_UART_TB);
  assign ctmr_next = upd(ctmr_reg, we_ct, wd, REG_RESET, ct_set, MASK_MF);
  assign stmr_next = upd(stmr_reg, we_st, wd, REG_RESET, st_set, mask_st);
  assign ee_lv_next = upd(ee_lv_reg, we_el, wd, REG_RESET, el_set, MASK_MF);
  assign pullup_next = upd(pullup_reg, we_pu, wd, REG_RESET, REG_RESET, MASK_PULLUP);

  // any event that sets a clear flag wakes the core; an already set flag does not
  wire [7:0] new0 = c0_set & ~ctrl0_reg & FLAGS_HI;
  wire [7:0] new1 = c1_set & ~ctrl1_reg & FLAGS_HI;
  wire [7:0] new2 = c2_set & ~uart_tb_reg & FLAGS_HI;
  wire [7:0] new3 = ct_set & ~ctmr_reg;
  wire [7:0] new4 = st_set & ~stmr_reg;
  wire [7:0] new5 = el_set & ~ee_lv_reg;
  wire wake_next = |(new0 | new1 | new2 | new3 | new4 | new5);

  // read data from next-state values so a read right after a write sees it
  wire [7:0] status_val = {3'h0, stack_full, SP_W'(sp_reg)};
  wire [7:0] rd_val =
    !in_map ? REG_RESET :
    (haddr[7:0] == OFS_EDGE) ? edge_next :
    (haddr[7:0] == OFS_CTRL0) ? ctrl0_next :
    (haddr[7:0] == OFS_CTRL1) ? ctrl1_next :
    (haddr[7:0] == OFS_UART_TB) ? uart_tb_next :
    (haddr[7:0] == OFS_CTMR) ? ctmr_next :
    (haddr[7:0] == OFS_STMR) ? stmr_next :
    (haddr[7:0] == OFS_EE_LV) ? ee_lv_next :
    (haddr[7:0] == OFS_PULLUP) ? pullup_next :
    (haddr[7:0] == OFS_STATUS) ? status_val : REG_RESET;

  // stack pointer and the addresses it drives
  wire [SP_W-1:0] sp_dec = sp_reg - SP_ONE;
  wire [SA_W-1:0] push_addr = SA_W'(sp_reg);
  wire [SA_W-1:0] pop_addr = SA_W'(sp_dec);
  wire [SP_W-1:0] sp_next = svc_go ? sp_reg + SP_ONE : (pop_go ? sp_dec : sp_reg);
  wire [PC_W-1:0] vec_next = VEC_ADDR[svc_idx*PC_W +: PC_W];

  vic_stack_mem #(
    .W(PC_W),
    .DEPTH(STACK_DEPTH),
    .AW(SA_W)
  ) u_stack (
    .clk(hclk),
    .rst_n(hresetn),
    .we(svc_go),
    .waddr(push_addr),
    .wdata(core_next_pc),
    .re(pop_go),
    .raddr(pop_addr),
    .rdata(resume_pc)
  );

  // bus slave: zero wait states, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_ofs_reg <= REG_RESET;
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
    end else begin
      wr_pend_reg <= wr_go;
      wr_ofs_reg <= haddr[7:0];
      hrdata <= rd_go ? {24'h0, rd_val} : '0;
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
    end
  end

  // register file, all bits zero at reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      edge_reg <= REG_RESET;
      ctrl0_reg <= REG_RESET;
      ctrl1_reg <= REG_RESET;
      uart_tb_reg <= REG_RESET;
      ctmr_reg <= REG_RESET;
      stmr_reg <= REG_RESET;
      ee_lv_reg <= REG_RESET;
      pullup_reg <= REG_RESET;
    end else begin
      edge_reg <= edge_next;
      ctrl0_reg <= ctrl0_next;
      ctrl1_reg <= ctrl1_next;
      uart_tb_reg <= uart_tb_next;
      ctmr_reg <= ctmr_next;
      stmr_reg <= stmr_next;
      ee_lv_reg <= ee_lv_next;
      pullup_reg <= pullup_next;
    end
  end

  // pin synchronisers; the second stage and its delayed copy feed the edge logic
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_reg <= 2'h0;
      pin_s2_reg <= 2'h0;
      pin_prev_reg <= 2'h0;
    end else begin
      pin_s1_reg <= ext_pin;
      pin_s2_reg <= pin_s1_reg;
      pin_prev_reg <= pin_s2_reg;
    end
  end

  // core side: call pulse with vector, resume pulse with popped pc
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sp_reg <= '0;
      irq_call <= 1'b0;
      irq_vector <= '0;
      pop_reg <= 1'b0;
      resume_valid <= 1'b0;
      wake_req <= 1'b0;
      ext_pullup_en <= 2'h0;
    end else begin
      sp_reg <= sp_next;
      irq_call <= svc_go;
      irq_vector <= svc_go ? vec_next : irq_vector;
      pop_reg <= pop_go;
      resume_valid <= pop_go;
      wake_req <= wake_next;
      ext_pullup_en <= pullup_next[1:0];
    end
  end
endmodule : vic_ctrl

// File: sim/vic_ctrl_props.sv
// concurrent checks on the interrupt controller ports
`timescale 1ns/1ps
module vic_ctrl_props
  import vic_pkg::*;
#(
  parameter int STACK_DEPTH = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic return_from_irq,
  input wire logic irq_call,
  input wire logic resume_valid,
  input wire logic [1:0] ext_pullup_en
);
  logic wr_ph;
  logic rd_ph;
  logic bad_q;
  logic [7:0] addr_q;
  logic [7:0] depth_q;
  wire logic take = hsel && hready && htrans == HTRANS_NONSEQ;
  wire logic ctrl0_off = wr_ph && addr_q == OFS_CTRL0 && !hwdata[C0_GLOBAL_EN];
  // depth rebuilt from calls and resumes, since the status register is not at the ports
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph <= 1'b0;
      rd_ph <= 1'b0;
      bad_q <= 1'b0;
      addr_q <= 8'h00;
      depth_q <= 8'h00;
    end else begin
      wr_ph <= take && hwrite;
      rd_ph <= take && !hwrite;
      bad_q <= haddr[31:8] != 24'h000000 || haddr[7:0] > OFS_STATUS;
      addr_q <= haddr[7:0];
      depth_q <= depth_q + 8'(irq_call) - 8'(resume_valid);
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_rdata_idle_zero: assert property (!rd_ph |-> hrdata == 32'h0)
    else $error("read data outside a read data phase");
  a_unmapped_read_zero: assert property (rd_ph && bad_q |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_pullup_copy: assert property (wr_ph && addr_q == OFS_PULLUP |=> ##1 ext_pullup_en == $past(hwdata[1:0], 2))
    else $error("pull-high select not applied");
  a_global_off_blocks: assert property (ctrl0_off && !return_from_irq |-> ##2 !irq_call)
    else $error("service with global enable off");
  a_call_single: assert property (irq_call |=> !irq_call)
    else $error("second service without global enable");
  a_return_wins: assert property (return_from_irq |=> !irq_call)
    else $error("service taken on a return cycle");
  a_resume_cause: assert property (resume_valid |-> $past(return_from_irq))
    else $error("resume without return");
  a_stack_full: assert property (depth_q == STACK_DEPTH |-> !irq_call)
    else $error("service with full stack");
  c_service: cover property (irq_call);
  c_resume: cover property (resume_valid);
  c_full: cover property (depth_q == STACK_DEPTH);
endmodule : vic_ctrl_props

bind vic_ctrl vic_ctrl_props #(.STACK_DEPTH(STACK_DEPTH)) vic_ctrl_props_i (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .return_from_irq(return_from_irq), .irq_call(irq_call), .resume_valid(resume_valid),
  .ext_pullup_en(ext_pullup_en)
);

// File: sim/vic_core_model.sv
// processor core model: follows calls and returns
`timescale 1ns/1ps
module vic_core_model #(
  parameter int PC_W = 14
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic irq_call,
  input wire logic [PC_W-1:0] irq_vector,
  input wire logic resume_valid,
  input wire logic [PC_W-1:0] resume_pc,
  input wire logic ret_req,
  output logic [PC_W-1:0] core_next_pc,
  output logic return_from_irq
);
  // pc steps each cycle unless a call loads the vector or a resume loads the popped pc
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_next_pc <= PC_W'(16'h0100);
      return_from_irq <= 1'b0;
    end else begin
      return_from_irq <= ret_req;
      if (irq_call) core_next_pc <= irq_vector;
      else if (resume_valid) core_next_pc <= resume_pc;
      else core_next_pc <= core_next_pc + 1'b1;
    end
  end
endmodule : vic_core_model

// File: sim/vic_ctrl_tb.sv
// self-checking bench for the vectored interrupt controller
`timescale 1ns/1ps
module vic_ctrl_tb;
  import vic_pkg::*;
  // last place is unmapped
  localparam logic [7:0] RW_ADR [10] = '{OFS_EDGE, OFS_CTRL0, OFS_CTRL1, OFS_UART_TB, OFS_CTMR,
    OFS_STMR, OFS_EE_LV, OFS_PULLUP, OFS_STATUS, 8'h24};
  localparam logic [7:0] RW_MSK [10] = '{8'h0F, 8'h7F, 8'hFF, 8'h77, 8'h33, 8'h33, 8'h33,
    8'h03, 8'h00, 8'h00};
  localparam logic [7:0] EV_REG [11] = '{OFS_CTRL0, OFS_CTRL1, OFS_UART_TB, OFS_UART_TB,
    OFS_UART_TB, OFS_CTMR, OFS_CTMR, OFS_STMR, OFS_STMR, OFS_EE_LV, OFS_EE_LV};
  localparam logic [7:0] EV_BIT [11] = '{8'h40, 8'h80, 8'h40, 8'h10, 8'h20, 8'h20, 8'h10,
    8'h20, 8'h10, 8'h20, 8'h10};
  localparam logic [7:0] EV_GRP [11] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h10, 8'h10,
    8'h20, 8'h20, 8'h40, 8'h40};
  localparam int ORD [4] = '{V_ADC, V_MF0, V_SPI, V_UART};
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] ext_pin = 2'h0;
  logic [10:0] ev = 11'h000;
  logic ret_req = 1'b0;
  logic hready, hresp, return_from_irq, irq_call, resume_valid, wake_req, g;
  logic [31:0] hrdata, rd, wd;
  logic [13:0] core_next_pc, irq_vector, resume_pc, pc_d;
  logic [13:0] pushq [$];
  logic [1:0] ext_pullup_en;
  logic [15:0] lfsr = 16'h0017;
  int fail_count = 0;
  int compares = 0;
  always #12.5 hclk = ~hclk;
  vic_ctrl vic_ctrl_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .ext_pin(ext_pin), .adc_done(ev[0]), .spi_event(ev[1]),
    .uart_event(ev[2]), .timebase0_event(ev[3]), .timebase1_event(ev[4]),
    .compact_tmr_match_a(ev[5]), .compact_tmr_match_p(ev[6]), .standard_tmr_match_a(ev[7]),
    .standard_tmr_match_p(ev[8]), .eeprom_write_done(ev[9]), .low_volt_detect(ev[10]),
    .core_next_pc(core_next_pc), .return_from_irq(return_from_irq), .irq_call(irq_call),
    .irq_vector(irq_vector), .resume_valid(resume_valid), .resume_pc(resume_pc),
    .wake_req(wake_req), .ext_pullup_en(ext_pullup_en)
  );
  vic_core_model vic_core_model_i (
    .hclk(hclk), .hresetn(hresetn), .irq_call(irq_call), .irq_vector(irq_vector),
    .resume_valid(resume_valid), .resume_pc(resume_pc), .ret_req(ret_req),
    .core_next_pc(core_next_pc), .return_from_irq(return_from_irq)
  );
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  task automatic cmpw(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: data %h, expected %h", $time, got, exp);
    end
  endtask : cmpw
  task automatic cmp1(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask : cmp1
  task automatic cmpa(input logic [13:0] got, input logic [13:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: address %h, expected %h", $time, got, exp);
    end
  endtask : cmpa
  task automatic tally_and_finish();
    $display("compares %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h000000, a};
    hwrite <= w;
    // address phase stands until hready is seen high at a rising edge
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    // data phase ends at the next rising edge with hready; read data taken there
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 32'h0);
    cmpw(rd, {24'h000000, e});
    cmp1(hresp, HRESP_OKAY);
  endtask : rdc
  task automatic pulse(input logic [10:0] m);
    @(posedge hclk);
    ev <= m;
    @(posedge hclk);
    ev <= 11'h000;
    @(negedge hclk);
  endtask : pulse
  task automatic pin_edge(input int p, input logic v);
    @(posedge hclk);
    ext_pin[p] <= v;
    repeat (6) @(negedge hclk);
  endtask : pin_edge
  task automatic wait_call(output logic got);
    int n;
    n = 0;
    got = 1'b0;
    while (!got && n < 30) begin
      @(negedge hclk);
      got = irq_call === 1'b1;
      n++;
    end
  endtask : wait_call
  task automatic expect_call(input int vi);
    logic got;
    wait_call(got);
    cmp1(got, 1'b1);
    cmpa(irq_vector, 14'(4 * vi + 4));
  endtask : expect_call
  // random delay lets the core answer slowly as well as promptly
  task automatic ret();
    lfsr = lfsr_next(lfsr);
    repeat (lfsr[1:0]) @(posedge hclk);
    @(posedge hclk);
    ret_req <= 1'b1;
    @(posedge hclk);
    ret_req <= 1'b0;
    repeat (2) @(negedge hclk);
  endtask : ret
  // pushed address is the core pc of the cycle before the call pulse
  always @(posedge hclk) begin
    if (irq_call === 1'b1) pushq.push_back(pc_d);
    if (resume_valid === 1'b1 && pushq.size() > 0) cmpa(resume_pc, pushq.pop_back());
    pc_d <= core_next_pc;
  end
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 10; i++) rdc(RW_ADR[i], 8'h00);
    for (int i = 0; i < 10; i++) begin
      lfsr = lfsr_next(lfsr);
      wd = {lfsr, lfsr} & ~32'(RW_ADR[i] == OFS_CTRL0);
      bus(1'b1, RW_ADR[i], wd);
      rdc(RW_ADR[i], wd[7:0] & RW_MSK[i]);
    end
    for (int i = 0; i < 10; i++) bus(1'b1, RW_ADR[i], 32'h0);
    $display("test registers done");
    for (int i = 0; i < 11; i++) begin
      pulse(11'(1) << i);
      cmp1(wake_req, 1'b1);
      rdc(EV_REG[i], EV_BIT[i]);
      rdc(OFS_CTRL1, EV_GRP[i]);
      bus(1'b1, EV_REG[i], 32'h0);
      bus(1'b1, OFS_CTRL1, 32'h0);
    end
    $display("test events done");
    for (int p = 0; p < 2; p++) for (int c = 0; c < 4; c++) begin
      bus(1'b1, OFS_EDGE, 32'(c) << (2 * p));
      pin_edge(p, 1'b1);
      rdc(OFS_CTRL0, c[0] ? 8'(8'h10 << p) : 8'h00);
      bus(1'b1, OFS_CTRL0, 32'h0);
      pin_edge(p, 1'b0);
      rdc(OFS_CTRL0, c[1] ? 8'(8'h10 << p) : 8'h00);
      bus(1'b1, OFS_CTRL0, 32'h0);
    end
    $display("test pins done");
    bus(1'b1, OFS_CTRL0, 32'h09);
    pulse(11'h001);
    expect_call(V_ADC);
    rdc(OFS_CTRL0, 8'h08);
    pulse(11'h001);
    wait_call(g);
    cmp1(g, 1'b0);
    rdc(OFS_CTRL0, 8'h48);
    ret();
    expect_call(V_ADC);
    ret();
    rdc(OFS_CTRL0, 8'h09);
    bus(1'b1, OFS_CTRL0, 32'h08);
    bus(1'b1, OFS_CTRL1, 32'h09);
    bus(1'b1, OFS_UART_TB, 32'h04);
    bus(1'b1, OFS_CTMR, 32'h02);
    pulse(11'h02F);
    bus(1'b1, OFS_CTRL0, 32'h49);
    for (int i = 0; i < 4; i++) begin
      expect_call(ORD[i]);
      ret();
    end
    wait_call(g);
    cmp1(g, 1'b0);
    rdc(OFS_CTMR, 8'h22);
    rdc(OFS_CTRL1, 8'h09);
    rdc(OFS_UART_TB, 8'h14);
    $display("test service done");
    bus(1'b1, OFS_CTRL0, 32'h08);
    repeat (8) begin
      pulse(11'h001);
      bus(1'b1, OFS_CTRL0, 32'h49);
      expect_call(V_ADC);
    end
    rdc(OFS_STATUS, 8'h18);
    pulse(11'h001);
    bus(1'b1, OFS_CTRL0, 32'h49);
    wait_call(g);
    cmp1(g, 1'b0);
    ret();
    expect_call(V_ADC);
    repeat (8) ret();
    rdc(OFS_STATUS, 8'h00);
    cmp1(pushq.size() == 0, 1'b1);
    $display("test stack done");
    tally_and_finish();
  end
  // tests take under a thousand cycles; this limit of 16000 cycles is over fifteen times that
  initial begin
    #400000;
    fail_count++;
    tally_and_finish();
  end
endmodule : vic_ctrl_tb
